// *** common/smr_pkg.sv ***
/*
 * Constants and types shared by the software memory miss resource pair.
 * Assumes a core that sends set-control commands on the same clock as the block.
 */
`default_nettype none
package smr_pkg;

    // Resource selectors: one resource for read misses, one for write misses.
    localparam logic       res_read_miss               = 1'h0;
    localparam logic       res_write_miss              = 1'h1;

    // Mode bits understood by the set-control instruction.
    localparam logic [15:0] inuse_mode                 = 16'h0000;
    localparam logic [15:0] ie_mode                    = 16'h0002;
    localparam logic [15:0] run_mode                   = 16'h0007;

    // Values carried with the mode bits.
    localparam logic [31:0] sw_memory_enable_value     = 32'h0000_0001;
    localparam logic [31:0] sw_memory_disable_value    = 32'h0000_0000;
    localparam logic [31:0] signal_as_event_setting    = 32'h0000_0000;
    localparam logic [31:0] signal_as_interrupt_setting = 32'h0000_0001;
    localparam logic [31:0] miss_serviced_command      = 32'h0000_0001;

    // Reset values of the per-resource controls.
    localparam logic [1:0] enable_reset                = 2'h0;
    localparam logic [1:0] ie_irq_reset                = 2'h0;

    // Word addressing inside the mini-cache.
    localparam int         word_offset_bits            = 2;

    typedef enum logic [1:0] {
        st_idle,
        st_wait,
        st_complete
    } smr_fsm_type;

endpackage : smr_pkg

`default_nettype wire

// *** rtl/smr_minicache.sv ***
/*
 * Direct-mapped, word-wide mini-cache holding the software memory contents.
 * Assumes one writer per cycle; the caller merges fills and stores.
 */
`timescale 1ns/1ps
`default_nettype none

module smr_minicache #(
    parameter int AW    = 32,
    parameter int DW    = 32,
    parameter int LINES = 8
) (
    // Clock and reset
    input  wire logic          sys_clk,
    input  wire logic          rst,
    // Lookup
    input  wire logic [AW-1:0] look_addr,
    output logic               look_hit,
    output logic [DW-1:0]      look_data,
    // Write or fill
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [DW-1:0] wr_data
);
    localparam int IW   = $clog2(LINES);
    localparam int TAGW = AW - IW - smr_pkg::word_offset_bits;

    generate
        if (LINES < 2 || (1 << IW) != LINES || TAGW < 1) begin : g_bad
            $error("smr_minicache: LINES must be a power of two that fits the address");
        end
    endgenerate

    typedef struct packed {
        logic [LINES-1:0]           valid;
        logic [LINES-1:0][TAGW-1:0] tag;
        logic [LINES-1:0][DW-1:0]   data;
    } smr_mc_state_type;

    smr_mc_state_type st_q;
    smr_mc_state_type st_d;

    logic [IW-1:0]   look_idx;
    logic [TAGW-1:0] look_tag;
    logic [IW-1:0]   wr_idx;
    logic [TAGW-1:0] wr_tag;

    assign look_idx  = look_addr[smr_pkg::word_offset_bits +: IW];
    assign look_tag  = look_addr[AW-1 -: TAGW];
    assign wr_idx    = wr_addr[smr_pkg::word_offset_bits +: IW];
    assign wr_tag    = wr_addr[AW-1 -: TAGW];
    assign look_hit  = st_q.valid[look_idx] && (st_q.tag[look_idx] == look_tag);
    assign look_data = st_q.data[look_idx];

    always_comb begin
        st_d = st_q;
        // A write always allocates, so a serviced store lands in the cache.
        if (wr_en) begin
            st_d.valid[wr_idx] = 1'b1;
            st_d.tag[wr_idx]   = wr_tag;
            st_d.data[wr_idx]  = wr_data;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

endmodule : smr_minicache

`default_nettype wire

// *** rtl/smr_top.sv ***
/*
 * Software memory miss handling for one tile: a read miss and a write miss
 * resource sharing one mini-cache, configured by set-control commands.
 * Assumes the core, its accesses and its commands run on sys_clk.
 */
`timescale 1ns/1ps
`default_nettype none

module smr_top #(
    parameter int          AW         = 32,
    parameter int          DW         = 32,
    parameter int          LINES      = 8,
    parameter logic [31:0] SPACE_BASE = 32'h8000_0000,
    parameter logic [31:0] SPACE_MASK = 32'hC000_0000
) (
    // Clock and reset
    input  wire logic          sys_clk,
    input  wire logic          rst,
    // Set-control commands from the core
    input  wire logic          ctl_valid,
    input  wire logic          ctl_res,
    input  wire logic [15:0]   ctl_mode,
    input  wire logic [31:0]   ctl_value,
    // Memory access from the core
    input  wire logic          acc_valid,
    input  wire logic          acc_write,
    input  wire logic [AW-1:0] acc_addr,
    input  wire logic [DW-1:0] acc_wdata,
    output logic               acc_ready,
    output logic               acc_done,
    output logic [DW-1:0]      acc_rdata,
    // Fill path used by the servicing software
    input  wire logic          fill_valid,
    input  wire logic [AW-1:0] fill_addr,
    input  wire logic [DW-1:0] fill_data,
    // Miss signalling, index 0 read resource, index 1 write resource
    output logic [1:0]         miss_event,
    output logic [1:0]         miss_irq,
    output logic [AW-1:0]      miss_addr,
    // Accesses outside the software memory path
    output logic               pass_req,
    output logic               pass_write,
    output logic [AW-1:0]      pass_addr,
    output logic [DW-1:0]      pass_wdata
);
    generate
        if (AW != 32) begin : g_bad_aw
            $error("smr_top: the address space window needs AW of 32");
        end
    endgenerate

    typedef struct packed {
        smr_pkg::smr_fsm_type state;
        logic [1:0]           enable;
        logic [1:0]           ie_irq;
        logic                 pend_write;
        logic [AW-1:0]        addr;
        logic [DW-1:0]        wdata;
        logic                 ready;
        logic                 done;
        logic [DW-1:0]        rdata;
        logic [1:0]           sig_event;
        logic [1:0]           sig_irq;
        logic                 pass_req;
        logic                 pass_write;
        logic [AW-1:0]        pass_addr;
        logic [DW-1:0]        pass_wdata;
    } smr_top_state_type;

    smr_top_state_type st_q;
    smr_top_state_type st_d;

    logic          accept;
    logic          in_space;
    logic          sel;
    logic          svc;
    logic          look_hit;
    logic [DW-1:0] look_data;
    logic [AW-1:0] look_addr;
    logic          wr_en;
    logic [AW-1:0] wr_addr;
    logic [DW-1:0] wr_data;

    assign accept   = acc_valid && st_q.ready && (st_q.state == smr_pkg::st_idle);
    assign in_space = (acc_addr & SPACE_MASK) == SPACE_BASE;
    assign sel      = in_space && st_q.enable[acc_write];
    assign svc      = ctl_valid && (ctl_mode == smr_pkg::run_mode)
                      && (ctl_value == smr_pkg::miss_serviced_command);
    assign look_addr = (st_q.state == smr_pkg::st_idle) ? acc_addr : st_q.addr;

    smr_minicache #(
        .AW    (AW),
        .DW    (DW),
        .LINES (LINES)
    ) u_cache (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .look_addr (look_addr),
        .look_hit  (look_hit),
        .look_data (look_data),
        .wr_en     (wr_en),
        .wr_addr   (wr_addr),
        .wr_data   (wr_data)
    );

    always_comb begin
        st_d          = st_q;
        st_d.done     = 1'b0;
        st_d.pass_req = 1'b0;
        wr_en         = fill_valid;
        wr_addr       = fill_addr;
        wr_data       = fill_data;
        // Each resource keeps its own controls.
        for (int r = 0; r < 2; r++) begin
            if (ctl_valid && (ctl_res == r[0])) begin
                if (ctl_mode == smr_pkg::inuse_mode) begin
                    if (ctl_value == smr_pkg::sw_memory_enable_value) begin
                        st_d.enable[r] = 1'b1;
                    end else if (ctl_value == smr_pkg::sw_memory_disable_value) begin
                        st_d.enable[r] = 1'b0;
                    end
                end
                if (ctl_mode == smr_pkg::ie_mode) begin
                    if (ctl_value == smr_pkg::signal_as_interrupt_setting) begin
                        st_d.ie_irq[r] = 1'b1;
                    end else if (ctl_value == smr_pkg::signal_as_event_setting) begin
                        st_d.ie_irq[r] = 1'b0;
                    end
                end
            end
        end
        case (st_q.state)
            smr_pkg::st_idle: begin
                if (accept) begin
                    if (!sel) begin
                        st_d.pass_req   = 1'b1;
                        st_d.pass_write = acc_write;
                        st_d.pass_addr  = acc_addr;
                        st_d.pass_wdata = acc_wdata;
                    end else if (look_hit) begin
                        wr_en      = acc_write;
                        wr_addr    = acc_addr;
                        wr_data    = acc_wdata;
                        st_d.done  = 1'b1;
                        st_d.rdata = acc_write ? st_q.rdata : look_data;
                    end else begin
                        st_d.state      = smr_pkg::st_wait;
                        st_d.pend_write = acc_write;
                        st_d.addr       = acc_addr;
                        st_d.wdata      = acc_wdata;
                    end
                end
            end
            smr_pkg::st_wait: begin
                // Held until the owning resource is serviced.
                if (svc && (ctl_res == st_q.pend_write)) begin
                    st_d.state = smr_pkg::st_complete;
                end
            end
            smr_pkg::st_complete: begin
                if (st_q.pend_write) begin
                    wr_en   = 1'b1;
                    wr_addr = st_q.addr;
                    wr_data = st_q.wdata;
                end else begin
                    st_d.rdata = look_data;
                end
                st_d.done  = 1'b1;
                st_d.state = smr_pkg::st_idle;
            end
            default: begin
                st_d.state = smr_pkg::st_idle;
            end
        endcase
        // The miss level follows the current mode so a mode change while pending takes effect.
        for (int r = 0; r < 2; r++) begin
            st_d.sig_event[r] = (st_d.state == smr_pkg::st_wait)
                                && (st_d.pend_write == r[0]) && !st_d.ie_irq[r];
            st_d.sig_irq[r]   = (st_d.state == smr_pkg::st_wait)
                                && (st_d.pend_write == r[0]) && st_d.ie_irq[r];
        end
        st_d.ready = (st_d.state == smr_pkg::st_idle);
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st_q        <= '0;
            st_q.enable <= smr_pkg::enable_reset;
            st_q.ie_irq <= smr_pkg::ie_irq_reset;
        end else begin
            st_q <= st_d;
        end
    end

    assign acc_ready  = st_q.ready;
    assign acc_done   = st_q.done;
    assign acc_rdata  = st_q.rdata;
    assign miss_event = st_q.sig_event;
    assign miss_irq   = st_q.sig_irq;
    assign miss_addr  = st_q.addr;
    assign pass_req   = st_q.pass_req;
    assign pass_write = st_q.pass_write;
    assign pass_addr  = st_q.pass_addr;
    assign pass_wdata = st_q.pass_wdata;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_enable_switch: assert property (
        ctl_valid && ctl_mode == smr_pkg::inuse_mode
        && ctl_value == smr_pkg::sw_memory_enable_value
        |=> st_q.enable[$past(ctl_res)])
        else $error("in-use write did not enable resource");

    a_irq_select: assert property (
        ctl_valid && ctl_mode == smr_pkg::ie_mode
        && ctl_value == smr_pkg::signal_as_interrupt_setting
        |=> st_q.ie_irq[$past(ctl_res)])
        else $error("interrupt mode not taken");

    a_event_default: assert property (
        !st_q.ie_irq[0] && !(ctl_valid && ctl_res == 1'b0 && ctl_mode == smr_pkg::ie_mode)
        |=> !st_q.ie_irq[0])
        else $error("read resource left event mode unasked");

    a_route_cache: assert property (
        accept |=> (pass_req == !$past(sel)))
        else $error("access routed to wrong path");

    a_read_miss_sig: assert property (
        accept && sel && !look_hit && !acc_write |=> (miss_event[0] || miss_irq[0])
        && !miss_event[1] && !miss_irq[1] && miss_addr == $past(acc_addr))
        else $error("read miss not signalled on read resource");

    a_resources_apart: assert property (
        accept && sel && !look_hit && acc_write |=> (miss_event[1] ^ miss_irq[1])
        && !miss_event[0] && !miss_irq[0])
        else $error("write miss leaked to read resource");

    a_hold_pending: assert property (
        st_q.state == smr_pkg::st_wait && !svc |=> !acc_done && !acc_ready)
        else $error("pending access completed without service");

    a_service_done: assert property (
        st_q.state == smr_pkg::st_wait && svc && ctl_res == st_q.pend_write
        |-> ##1 (miss_event == 2'h0 && miss_irq == 2'h0) ##1 (acc_done && acc_ready))
        else $error("serviced miss did not complete in two cycles");

endmodule : smr_top

`default_nettype wire

// *** bench/smr_svc_model.sv ***
/* Core-side servicing model: fills the missed word, then reports service.
   Assumes the bench drives on the falling edge of sys_clk. */
`timescale 1ns/1ps
`default_nettype none
module smr_svc_model (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // Miss view and pacing
    input  wire logic [1:0]  miss_pend,
    input  wire logic [31:0] miss_addr,
    input  wire logic [7:0]  svc_delay,
    // Fill and service report
    output logic             fill_valid,
    output logic [31:0]      fill_addr,
    output logic [31:0]      fill_data,
    output logic             svc_valid,
    output logic             svc_res
);
    initial begin
        fill_valid = 1'b0;
        svc_valid = 1'b0;
        svc_res = 1'b0;
        fill_addr = 32'h0;
        fill_data = 32'h0;
        forever begin
            @(negedge sys_clk);
            // Idle lines toggle so a stale value can never look valid.
            fill_addr = ~fill_addr;
            fill_data = ~fill_data;
            if (!rst && miss_pend != 2'h0) begin
                repeat (svc_delay) @(negedge sys_clk);
                fill_valid = 1'b1;
                fill_addr = miss_addr;
                fill_data = miss_addr ^ 32'h5A5A_0F0F;
                @(negedge sys_clk);
                fill_valid = 1'b0;
                svc_res = miss_pend[1];
                svc_valid = 1'b1;
                @(negedge sys_clk);
                svc_valid = 1'b0;
            end
        end
    end
endmodule : smr_svc_model
`default_nettype wire

// *** bench/test_software_memory_miss_resource.sv ***
/* Self-checking bench for the miss resource pair with a servicing model.
   Assumes default parameters of smr_top and falling-edge stimulus. */
`timescale 1ns/1ps
`default_nettype none
module test_software_memory_miss_resource;
    logic        sys_clk, rst, tb_valid, c_res, acc_valid, acc_write;
    logic        acc_ready, acc_done, fill_valid, pass_req, pass_write;
    logic        svc_valid, svc_res;
    logic [15:0] c_mode;
    logic [31:0] c_val, acc_addr, acc_wdata, acc_rdata, fill_addr, fill_data;
    logic [31:0] miss_addr, pass_addr, pass_wdata;
    logic [1:0]  miss_event, miss_irq;
    logic [7:0]  svc_delay;
    int          fail_count, n_checks, i;

    smr_top i_dut (.sys_clk(sys_clk), .rst(rst),
        .ctl_valid(tb_valid | svc_valid), .ctl_res(tb_valid ? c_res : svc_res),
        .ctl_mode(tb_valid ? c_mode : smr_pkg::run_mode),
        .ctl_value(tb_valid ? c_val : smr_pkg::miss_serviced_command),
        .acc_valid(acc_valid), .acc_write(acc_write), .acc_addr(acc_addr),
        .acc_wdata(acc_wdata), .acc_ready(acc_ready), .acc_done(acc_done),
        .acc_rdata(acc_rdata), .fill_valid(fill_valid), .fill_addr(fill_addr),
        .fill_data(fill_data), .miss_event(miss_event), .miss_irq(miss_irq),
        .miss_addr(miss_addr), .pass_req(pass_req), .pass_write(pass_write),
        .pass_addr(pass_addr), .pass_wdata(pass_wdata));
    smr_svc_model i_svc (.sys_clk(sys_clk), .rst(rst),
        .miss_pend(miss_event | miss_irq), .miss_addr(miss_addr),
        .svc_delay(svc_delay), .fill_valid(fill_valid), .fill_addr(fill_addr),
        .fill_data(fill_data), .svc_valid(svc_valid), .svc_res(svc_res));

    task automatic check(input string what, input logic [31:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
            fail_count++;
        end
    endtask : check

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : give_verdict

    task automatic ctl(input logic res, input logic [15:0] mode, input logic [31:0] v);
        @(negedge sys_clk);
        tb_valid = 1'b1;
        c_res = res;
        c_mode = mode;
        c_val = v;
        @(negedge sys_clk);
        tb_valid = 1'b0;
    endtask : ctl

    // Returns at the falling edge of the cycle after the access is taken.
    task automatic acc(input logic w, input logic [31:0] a, d);
        @(negedge sys_clk);
        acc_valid = 1'b1;
        acc_write = w;
        acc_addr = a;
        acc_wdata = d;
        for (i = 0; i < 50 && acc_ready !== 1'b1; i++) @(negedge sys_clk);
        @(negedge sys_clk);
        acc_valid = 1'b0;
        acc_addr = ~a;
        acc_wdata = ~d;
    endtask : acc

    task automatic wait_done();
        for (i = 0; i < 60 && acc_done !== 1'b1; i++) @(negedge sys_clk);
        check("acc_done", 32'(acc_done), 32'h1);
    endtask : wait_done

    task automatic t_disabled();
        acc(1'b0, 32'h8000_0010, 32'h0);
        check("pass_req", 32'(pass_req), 32'h1);
        check("pass_addr", pass_addr, 32'h8000_0010);
        check("acc_done", 32'(acc_done), 32'h0);
        $display("test disabled done");
    endtask : t_disabled

    task automatic t_read_miss();
        ctl(smr_pkg::res_read_miss, smr_pkg::inuse_mode, smr_pkg::sw_memory_enable_value);
        acc(1'b0, 32'h8000_0020, 32'h0);
        check("miss_event", 32'(miss_event), 32'h1);
        check("miss_irq", 32'(miss_irq), 32'h0);
        check("miss_addr", miss_addr, 32'h8000_0020);
        check("acc_ready", 32'(acc_ready), 32'h0);
        wait_done();
        check("rdata", acc_rdata, 32'h8000_0020 ^ 32'h5A5A_0F0F);
        acc(1'b0, 32'h8000_0020, 32'h0);
        check("hit done", 32'(acc_done), 32'h1);
        check("hit rdata", acc_rdata, 32'h8000_0020 ^ 32'h5A5A_0F0F);
        acc(1'b0, 32'h0000_0020, 32'h0);
        check("outside pass", 32'(pass_req), 32'h1);
        $display("test read miss done");
    endtask : t_read_miss

    task automatic t_write_irq();
        acc(1'b1, 32'h8000_0040, 32'h1234_ABCD);
        check("store pass", 32'(pass_req), 32'h1);
        check("pass_write", 32'(pass_write), 32'h1);
        check("pass_wdata", pass_wdata, 32'h1234_ABCD);
        svc_delay = 8'h8;
        ctl(smr_pkg::res_write_miss, smr_pkg::inuse_mode, smr_pkg::sw_memory_enable_value);
        ctl(smr_pkg::res_write_miss, smr_pkg::ie_mode, smr_pkg::signal_as_interrupt_setting);
        acc(1'b1, 32'h8000_0040, 32'h1234_ABCD);
        check("miss_irq", 32'(miss_irq), 32'h2);
        check("miss_event", 32'(miss_event), 32'h0);
        wait_done();
        acc(1'b0, 32'h8000_0040, 32'h0);
        check("store kept", acc_rdata, 32'h1234_ABCD);
        ctl(smr_pkg::res_write_miss, smr_pkg::ie_mode, smr_pkg::signal_as_event_setting);
        acc(1'b1, 32'h8000_0080, 32'h0BAD_F00D);
        check("event again", 32'(miss_event), 32'h2);
        ctl(smr_pkg::res_read_miss, smr_pkg::run_mode, smr_pkg::miss_serviced_command);
        check("wrong res svc", 32'(miss_event), 32'h2);
        check("still pending", 32'(acc_done), 32'h0);
        wait_done();
        acc(1'b1, 32'h8000_0080, 32'h600D_CAFE);
        check("hit store", 32'(acc_done), 32'h1);
        acc(1'b0, 32'h8000_0080, 32'h0);
        check("hit store data", acc_rdata, 32'h600D_CAFE);
        $display("test write irq done");
    endtask : t_write_irq

    task automatic t_off();
        ctl(smr_pkg::res_read_miss, smr_pkg::inuse_mode, smr_pkg::sw_memory_disable_value);
        acc(1'b0, 32'h8000_0020, 32'h0);
        check("off pass", 32'(pass_req), 32'h1);
        $display("test off done");
    endtask : t_off

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    initial begin
        #(5000 * 25);
        fail_count++;
        give_verdict();
    end

    initial begin
        rst = 1'b1;
        {tb_valid, c_res, acc_valid, acc_write} = 4'h0;
        {c_mode, c_val, acc_addr, acc_wdata} = '0;
        svc_delay = 8'h1;
        repeat (10) @(negedge sys_clk);
        check("reset ready", 32'(acc_ready), 32'h0);
        check("reset miss", 32'({miss_event, miss_irq}), 32'h0);
        rst = 1'b0;
        t_disabled();
        t_read_miss();
        t_write_irq();
        t_off();
        give_verdict();
    end
endmodule : test_software_memory_miss_resource
`default_nettype wire
